// *** cmig_pkg.sv ***
// shared constants and carrier types for the counter module glue
`default_nettype none
package cmig_pkg;
	// clock rate of clk_in in MHz
	localparam int CLK_MHZ = 25;
	// number of counter channels and data widths
	localparam int NCH = 5;
	localparam int DW = 16;
	localparam int VEC_W = 8;
	// apb address layout: module select bits above the register offset
	localparam int AW = 12;
	localparam int REG_AW = 8;
	localparam int BASE_W = AW - REG_AW;
	// register byte offsets
	localparam logic [REG_AW-1:0] OFF_DATA = 8'h00;
	localparam logic [REG_AW-1:0] OFF_CMD = 8'h04;
	localparam logic [REG_AW-1:0] OFF_IEN = 8'h08;
	localparam logic [REG_AW-1:0] OFF_PEND = 8'h0c;
	localparam logic [REG_AW-1:0] OFF_MCTL = 8'h10;
	localparam logic [REG_AW-1:0] OFF_VEC = 8'h14;
	// master control field position
	localparam int MCTL_ME_BIT = 0;
	// reset values
	localparam logic [NCH-1:0] IEN_RST = 5'h00;
	localparam logic [NCH-1:0] PEND_RST = 5'h00;
	localparam logic MASTER_RST = 1'b0;
	localparam logic [DW-1:0] DATA_RST = 16'h0000;
	localparam logic [31:0] RDATA_RST = 32'h00000000;
	// timer chip access time and glitch rejection window
	localparam int ACCESS_NS = 200;
	localparam int ACCESS_CYC = (ACCESS_NS * CLK_MHZ + 999) / 1000;
	localparam int FILT_NS = 200;
	localparam int FILT_CYC = (FILT_NS * CLK_MHZ + 999) / 1000;
	// synchroniser only, no extra stability window
	localparam int SYNC_ONLY = 1;
	// timer chip strobes, all active low except the command select
	typedef struct packed {
		logic cs_n;
		logic cmd_sel;
		logic rd_n;
		logic wr_n;
	} cmig_chip_ctl_t;
	localparam cmig_chip_ctl_t CHIP_IDLE = '{cs_n: 1'b1, cmd_sel: 1'b0, rd_n: 1'b1, wr_n: 1'b1};
	// one set of user counter inputs
	typedef struct packed {
		logic [NCH-1:0] source;
		logic [NCH-1:0] gate;
	} cmig_user_t;
endpackage : cmig_pkg
`default_nettype wire

// *** cmig_filter.sv ***
// synchroniser with stability window for asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module cmig_filter #(
	parameter int W = 1,
	parameter int STABLE = 1
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [W-1:0] din_in,
	output logic [W-1:0] dout_out
);
	localparam int CW = $clog2(STABLE + 1);
	localparam logic [CW-1:0] CNT_LAST = CW'(STABLE - 1);
	localparam logic [CW-1:0] CNT_ONE = CW'(1);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	logic [CW-1:0] cnt;

	// three stage synchroniser, s1 feeds only s2
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
		end else begin
			s1 <= din_in;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// accept a new value once stages agree for the whole window
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cnt <= '0;
			dout_out <= '0;
		end else if (s2 != s3 || s3 == dout_out) begin
			cnt <= '0; // spike or no change: restart window
		end else if (cnt == CNT_LAST) begin
			cnt <= '0;
			dout_out <= s3;
		end else begin
			cnt <= cnt + CNT_ONE;
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	property p_filter_window;
		$changed(dout_out) |-> $past(s3) == $past(s2);
	endproperty
	a_filter_window: assert property (p_filter_window) else $error("filter passed an unstable value");
endmodule : cmig_filter
`default_nettype wire

// *** cmig_top.sv ***
// bus glue, delayed reply, glitch rejection and interrupt logic of the counter module
// Overview of operation
// - halve the clock for the count reference
// - glitch filter every channel over/underflow output
// - answer every access, with an error when the module address does not match
// - supply switch vector on interrupt acknowledge
// - delay the reply for every access
// - reach timer chip through strobed data port
// - filtered output sets flag only when enabled
// - request interrupt when flag and master set
// - grant clears the master enable
// - setting master with pending flag requests again
// - counter inputs are nand of both inputs
`timescale 1ns/1ps
`default_nettype none
module cmig_top #(
	parameter int NUM_CH = cmig_pkg::NCH
) (
	input wire logic clk_in,
	input wire logic rst_in,
	// apb slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [cmig_pkg::AW-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// switches
	input wire logic [cmig_pkg::BASE_W-1:0] addr_sw_in,
	input wire logic [cmig_pkg::VEC_W-1:0] vector_sw_in,
	// interrupt request and acknowledge
	output logic irq_out,
	input wire logic iack_in,
	output logic [cmig_pkg::VEC_W-1:0] vector_out,
	output logic vector_valid_out,
	// timer chip port
	output cmig_pkg::cmig_chip_ctl_t chip_ctl_out,
	output logic [cmig_pkg::DW-1:0] chip_data_out,
	output logic chip_data_oe_n_out,
	input wire logic [cmig_pkg::DW-1:0] chip_data_in,
	input wire logic [NUM_CH-1:0] chip_ovf_in,
	output logic count_clk_out,
	// user inputs and counter inputs
	input wire cmig_pkg::cmig_user_t user_iso_in,
	input wire cmig_pkg::cmig_user_t user_ttl_in,
	output cmig_pkg::cmig_user_t chip_user_out
);
	import cmig_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_DONE = 3'b100
	} cmig_state_t;

	localparam int CNT_W = $clog2(ACCESS_CYC + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(ACCESS_CYC - 1);
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
	localparam int UW = 2 * NUM_CH;

	cmig_state_t state;
	cmig_state_t next_state;
	logic [CNT_W-1:0] wait_cnt;
	logic [BASE_W-1:0] addr_sw;
	logic [VEC_W-1:0] vector_sw;
	logic [DW-1:0] chip_rd;
	logic [NUM_CH-1:0] ovf_filt;
	logic [NUM_CH-1:0] ovf_prev;
	logic [NUM_CH-1:0] ovf_rise;
	logic [NUM_CH-1:0] int_en;
	logic [NUM_CH-1:0] req_flag;
	logic master_en;
	logic [UW-1:0] iso_sync;
	logic [UW-1:0] ttl_sync;
	logic [REG_AW-1:0] reg_off;
	logic addr_hit;
	logic reg_known;
	logic chip_reg;
	logic access_start;
	logic access_end;
	logic wr_done;
	logic grant;

	// switch settings and chip read data pass a plain synchroniser
	cmig_filter #(.W(BASE_W), .STABLE(SYNC_ONLY)) u_addr_sw (
		.clk_in(clk_in), .rst_in(rst_in), .din_in(addr_sw_in), .dout_out(addr_sw)
	);
	cmig_filter #(.W(VEC_W), .STABLE(SYNC_ONLY)) u_vec_sw (
		.clk_in(clk_in), .rst_in(rst_in), .din_in(vector_sw_in), .dout_out(vector_sw)
	);
	cmig_filter #(.W(DW), .STABLE(SYNC_ONLY)) u_chip_rd (
		.clk_in(clk_in), .rst_in(rst_in), .din_in(chip_data_in), .dout_out(chip_rd)
	);
	// glitch rejection on the channel over/underflow outputs
	cmig_filter #(.W(NUM_CH), .STABLE(FILT_CYC)) u_ovf (
		.clk_in(clk_in), .rst_in(rst_in), .din_in(chip_ovf_in), .dout_out(ovf_filt)
	);
	// user inputs, isolated and logic level
	cmig_filter #(.W(UW), .STABLE(SYNC_ONLY)) u_iso (
		.clk_in(clk_in), .rst_in(rst_in), .din_in(user_iso_in), .dout_out(iso_sync)
	);
	cmig_filter #(.W(UW), .STABLE(SYNC_ONLY)) u_ttl (
		.clk_in(clk_in), .rst_in(rst_in), .din_in(user_ttl_in), .dout_out(ttl_sync)
	);

	// counter source and gate inputs formed as a nand
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			chip_user_out <= '1;
		end else begin
			chip_user_out <= ~(iso_sync & ttl_sync);
		end
	end

	// count reference at half the clock rate
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			count_clk_out <= 1'b0;
		end else begin
			count_clk_out <= ~count_clk_out;
		end
	end

	// address decode
	assign reg_off = paddr_in[REG_AW-1:0];
	assign addr_hit = paddr_in[AW-1:REG_AW] == addr_sw;
	assign chip_reg = addr_hit && (reg_off == OFF_DATA || reg_off == OFF_CMD);
	assign reg_known = chip_reg || reg_off == OFF_IEN || reg_off == OFF_PEND
		|| reg_off == OFF_MCTL || reg_off == OFF_VEC;
	assign access_start = state == ST_IDLE && psel_in && penable_in;
	assign access_end = state == ST_WAIT && wait_cnt == CNT_LAST;
	assign wr_done = pready_out && psel_in && penable_in && pwrite_in && addr_hit;
	assign grant = iack_in && irq_out;

	// access sequencer: every access waits out the chip access time
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (access_start) begin
					next_state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (access_end) begin
					next_state = ST_DONE;
				end
			end
			ST_DONE: begin
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// wait counter for the delayed reply
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wait_cnt <= '0;
		end else if (state == ST_WAIT) begin
			wait_cnt <= wait_cnt + CNT_ONE;
		end else begin
			wait_cnt <= '0;
		end
	end

	// reply only after the wait has run out
	assign pready_out = state == ST_DONE;
	assign pslverr_out = pready_out && !(addr_hit && reg_known);

	// timer chip strobes held for the whole wait
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			chip_ctl_out <= CHIP_IDLE;
			chip_data_oe_n_out <= 1'b1;
			chip_data_out <= DATA_RST;
		end else if (access_start && chip_reg) begin
			chip_ctl_out.cs_n <= 1'b0;
			chip_ctl_out.cmd_sel <= reg_off == OFF_CMD;
			chip_ctl_out.rd_n <= pwrite_in;
			chip_ctl_out.wr_n <= ~pwrite_in;
			chip_data_oe_n_out <= ~pwrite_in;
			chip_data_out <= pwdata_in[DW-1:0];
		end else if (access_end) begin
			chip_ctl_out <= CHIP_IDLE;
			chip_data_oe_n_out <= 1'b1;
		end
	end

	// read data captured at the end of the wait
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			prdata_out <= RDATA_RST;
		end else if (access_end) begin
			prdata_out <= RDATA_RST;
			if (addr_hit && !pwrite_in) begin
				case (reg_off)
					OFF_DATA, OFF_CMD: prdata_out[DW-1:0] <= chip_rd;
					OFF_IEN: prdata_out[NUM_CH-1:0] <= int_en;
					OFF_PEND: prdata_out[NUM_CH-1:0] <= req_flag;
					OFF_MCTL: prdata_out[MCTL_ME_BIT] <= master_en;
					OFF_VEC: prdata_out[VEC_W-1:0] <= vector_sw;
					default: prdata_out <= RDATA_RST;
				endcase
			end
		end
	end

	// interrupt enable register
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			int_en <= IEN_RST;
		end else if (wr_done && reg_off == OFF_IEN) begin
			int_en <= pwdata_in[NUM_CH-1:0];
		end
	end

	// rising edge of each filtered channel output
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ovf_prev <= '0;
		end else begin
			ovf_prev <= ovf_filt;
		end
	end
	assign ovf_rise = ovf_filt & ~ovf_prev;

	// request flags: enabled edge sets, write of one clears, set wins
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			req_flag <= PEND_RST;
		end else if (wr_done && reg_off == OFF_PEND) begin
			req_flag <= (req_flag & ~pwdata_in[NUM_CH-1:0]) | (ovf_rise & int_en);
		end else begin
			req_flag <= req_flag | (ovf_rise & int_en);
		end
	end

	// master enable: software sets, grant clears
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			master_en <= MASTER_RST;
		end else if (grant) begin
			master_en <= 1'b0;
		end else if (wr_done && reg_off == OFF_MCTL) begin
			master_en <= pwdata_in[MCTL_ME_BIT];
		end
	end

	// bus interrupt request
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= (|req_flag) && master_en && !grant;
		end
	end

	// vector supplied on acknowledge
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			vector_out <= '0;
			vector_valid_out <= 1'b0;
		end else begin
			vector_valid_out <= grant;
			if (grant) begin
				vector_out <= vector_sw;
			end
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	sequence s_start;
		state == ST_IDLE && psel_in && penable_in;
	endsequence
	sequence s_held_off;
		!pready_out ##1 !pready_out ##1 !pready_out ##1 !pready_out ##1 !pready_out ##1 !pready_out;
	endsequence

	property p_clk_half;
		!$past(rst_in) |-> count_clk_out != $past(count_clk_out); // first edge out of reset holds
	endproperty
	a_clk_half: assert property (p_clk_half) else $error("count clock not halved");

	property p_decode;
		pready_out && !addr_hit |-> pslverr_out && prdata_out == RDATA_RST;
	endproperty
	a_decode: assert property (p_decode) else $error("answered a foreign address");

	property p_vector;
		iack_in && irq_out |=> vector_valid_out && vector_out == $past(vector_sw);
	endproperty
	a_vector: assert property (p_vector) else $error("wrong vector on acknowledge");

	property p_reply_delay;
		s_start |-> s_held_off ##1 pready_out;
	endproperty
	a_reply_delay: assert property (p_reply_delay) else $error("reply not delayed");

	property p_strobe;
		s_start ##0 chip_reg |=> !chip_ctl_out.cs_n [*5] ##1 chip_ctl_out.cs_n;
	endproperty
	a_strobe: assert property (p_strobe) else $error("chip select not held");

	property p_flag_set;
		|(ovf_rise & int_en) |=> (req_flag & $past(ovf_rise & int_en)) == $past(ovf_rise & int_en);
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("enabled event lost");

	property p_flag_gate;
		##1 ((req_flag & ~$past(req_flag)) & ~$past(ovf_rise & int_en)) == '0;
	endproperty
	a_flag_gate: assert property (p_flag_gate) else $error("flag set without enable");

	property p_irq;
		##1 irq_out == ($past(|req_flag) && $past(master_en) && !$past(grant));
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt request wrong");

	property p_grant_clear;
		iack_in && irq_out |=> !master_en ##1 !irq_out;
	endproperty
	a_grant_clear: assert property (p_grant_clear) else $error("grant left master set");

	property p_reenable;
		(|req_flag) && !master_en && !iack_in ##1 master_en && !iack_in |=> irq_out;
	endproperty
	a_reenable: assert property (p_reenable) else $error("no request after re-enable");

	property p_nand;
		##1 chip_user_out == ~($past(iso_sync) & $past(ttl_sync));
	endproperty
	a_nand: assert property (p_nand) else $error("counter input not nand");

	property p_clear;
		wr_done && reg_off == OFF_PEND && !(|ovf_rise)
			|=> (req_flag & $past(pwdata_in[NUM_CH-1:0])) == '0;
	endproperty
	a_clear: assert property (p_clear) else $error("flag not cleared");
endmodule : cmig_top
`default_nettype wire

// *** cmig_chip_model.sv ***
// behavioural timer chip on the far side of the strobed data port
`timescale 1ns/1ps
`default_nettype none
module cmig_chip_model (
	input wire logic clk_in,
	input wire cmig_pkg::cmig_chip_ctl_t ctl_in,
	input wire logic [cmig_pkg::DW-1:0] wdata_in,
	input wire logic oe_n_in,
	output logic [cmig_pkg::DW-1:0] rdata_out,
	output logic [cmig_pkg::DW-1:0] data_out,
	output logic [cmig_pkg::DW-1:0] cmd_out
);
	import cmig_pkg::*;
	logic [DW-1:0] last = 16'h0000;
	logic [DW-1:0] value;
	logic rd_act;
	// chip answers only while selected and read strobe low
	assign rd_act = !ctl_in.cs_n && !ctl_in.rd_n;
	assign value = ctl_in.cmd_sel ? cmd_out : data_out;
	// released bus shows the inverse of the last driven value
	assign rdata_out = rd_act ? value : ~last;
	// latch write data while selected with write strobe low
	always @(posedge clk_in) begin
		if (!ctl_in.cs_n && !ctl_in.wr_n && !oe_n_in) begin
			if (ctl_in.cmd_sel) begin
				cmd_out <= wdata_in;
			end else begin
				data_out <= wdata_in;
			end
		end
		if (rd_act) begin
			last <= value;
		end
	end
endmodule : cmig_chip_model
`default_nettype wire

// *** tb_cmig_top.sv ***
// self-checking testbench for the counter module glue
`timescale 1ns/1ps
`default_nettype none
module tb_cmig_top;
	import cmig_pkg::*;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [AW-1:0] pa = '0;
	logic [31:0] pwd = '0;
	logic [31:0] prd;
	logic [31:0] rd;
	logic [31:0] d;
	logic prdy, perr, er, irq, vval, cclk, oe_n, c;
	logic iack = 1'b0;
	logic [VEC_W-1:0] vec;
	logic [VEC_W-1:0] vsw = 8'h00;
	logic [BASE_W-1:0] asw = 4'h5;
	cmig_chip_ctl_t ctl;
	logic [DW-1:0] cdo, cdi, mdata, mcmd;
	logic [NCH-1:0] ovf = '0;
	cmig_user_t iso = '0;
	cmig_user_t ttl = '0;
	cmig_user_t cu;
	int failures = 0;
	int checks_done = 0;
	int cyc = 0;

	cmig_top cmig_top_i (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel),
		.penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd),
		.prdata_out(prd), .pready_out(prdy), .pslverr_out(perr),
		.addr_sw_in(asw), .vector_sw_in(vsw), .irq_out(irq), .iack_in(iack),
		.vector_out(vec), .vector_valid_out(vval), .chip_ctl_out(ctl),
		.chip_data_out(cdo), .chip_data_oe_n_out(oe_n), .chip_data_in(cdi),
		.chip_ovf_in(ovf), .count_clk_out(cclk), .user_iso_in(iso),
		.user_ttl_in(ttl), .chip_user_out(cu));

	cmig_chip_model cmig_chip_model_i (.clk_in(clk_in), .ctl_in(ctl),
		.wdata_in(cdo), .oe_n_in(oe_n), .rdata_out(cdi), .data_out(mdata),
		.cmd_out(mcmd));

	// clock and hang guard
	initial forever #20 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			failures++;
			final_report();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask : chk

	// one apb transfer; answer taken at the edge where pready is high
	task apb(input logic w, input logic [7:0] off, input logic [31:0] wd,
		input logic [BASE_W-1:0] s);
		int n;
		n = 0;
		@(posedge clk_in);
		psel <= 1'b1;
		pwr <= w;
		pa <= {s, off};
		pwd <= wd;
		@(posedge clk_in);
		pen <= 1'b1;
		// pready, read data and error are taken at the rising edge they stand at
		do begin
			@(posedge clk_in);
			n++;
		end while (prdy !== 1'b1 && n < 100);
		rd = prd;
		er = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		// taking edge, the wait cycles, then the reply edge
		chk(n, ACCESS_CYC + 2, "reply delay");
	endtask : apb

	task wr(input logic [7:0] off, input logic [31:0] wd);
		apb(1'b1, off, wd, asw);
	endtask : wr

	task rdc(input logic [7:0] off, input logic [31:0] exp, input string m);
		apb(1'b0, off, 32'h0, asw);
		chk(rd, exp, m);
	endtask : rdc

	// over/underflow pulse of given length on one channel
	task pulse(input int ch, input int len);
		@(posedge clk_in);
		ovf[ch] <= 1'b1;
		repeat (len) @(posedge clk_in);
		ovf[ch] <= 1'b0;
		repeat (20) @(posedge clk_in);
	endtask : pulse

	task tdone(input string s);
		$display("test %s done", s);
	endtask : tdone

	task final_report();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : final_report

	// main sequence
	initial begin
		void'($urandom(32'h6ef357c0));
		vsw = 8'($urandom);
		repeat (10) @(posedge clk_in);
		rst_in <= 1'b0;
		repeat (10) @(negedge clk_in);
		chk({22'h0, cu}, 32'h3ff, "user idle");
		c = cclk;
		@(negedge clk_in);
		chk(32'(cclk ^ c), 32'h1, "count clock");
		tdone("reset");
		wr(OFF_IEN, 32'h4);
		wr(OFF_MCTL, 32'h1);
		rdc(OFF_IEN, 32'h4, "enable readback");
		pulse(0, 10);
		rdc(OFF_PEND, 32'h0, "disabled channel set");
		pulse(2, 2);
		rdc(OFF_PEND, 32'h0, "glitch passed");
		@(negedge clk_in);
		chk(32'(irq), 32'h0, "irq without flag");
		pulse(2, 10);
		rdc(OFF_PEND, 32'h4, "enabled flag");
		@(negedge clk_in);
		chk(32'(irq), 32'h1, "irq missing");
		tdone("flags");
		@(posedge clk_in);
		iack <= 1'b1;
		@(posedge clk_in);
		iack <= 1'b0;
		@(negedge clk_in);
		chk(32'(vval), 32'h1, "vector valid");
		chk(32'(vec), 32'(vsw), "vector value");
		chk(32'(irq), 32'h0, "irq after grant");
		rdc(OFF_MCTL, 32'h0, "master after grant");
		rdc(OFF_PEND, 32'h4, "pending scan");
		wr(OFF_MCTL, 32'h1);
		repeat (2) @(negedge clk_in);
		chk(32'(irq), 32'h1, "irq on re-enable");
		wr(OFF_PEND, 32'h4);
		rdc(OFF_PEND, 32'h0, "flag clear");
		@(negedge clk_in);
		chk(32'(irq), 32'h0, "irq after clear");
		rdc(OFF_VEC, 32'(vsw), "vector register");
		tdone("grant");
		apb(1'b0, 8'h18, 32'h0, asw);
		chk({31'h0, er}, 32'h1, "unmapped error");
		chk(rd, 32'h0, "unmapped data");
		apb(1'b1, OFF_IEN, 32'h1f, ~asw);
		chk({31'h0, er}, 32'h1, "foreign address");
		rdc(OFF_IEN, 32'h4, "foreign write landed");
		tdone("decode");
		for (int i = 0; i < 4; i++) begin
			d = $urandom;
			wr(OFF_DATA, d);
			chk(32'(mdata), {16'h0, d[15:0]}, "chip data");
			rdc(OFF_DATA, {16'h0, d[15:0]}, "chip read");
			wr(OFF_CMD, {16'h0, d[31:16]});
			chk(32'(mcmd), {16'h0, d[31:16]}, "chip command");
			rdc(OFF_CMD, {16'h0, d[31:16]}, "chip command read");
			@(posedge clk_in);
			iso <= cmig_user_t'(10'($urandom));
			ttl <= cmig_user_t'(10'($urandom));
			repeat (6) @(negedge clk_in);
			chk({22'h0, cu}, {22'h0, 10'(~(iso & ttl))}, "user nand");
		end
		tdone("random");
		final_report();
	end
endmodule : tb_cmig_top
`default_nettype wire
